// >>> design/pin_mux_pkg.sv
// package: register map, field layout, reset values and state types of the data pin mux
package pin_mux_pkg;

  // widths of the data path and of the pin bundle
  localparam int WORD_W = 16;
  localparam int LINES = 3;
  localparam int SYNC_W = 20;

  // register offsets on the bus (byte addresses, low eight bits decoded)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CHAIN = 8'h0C;

  // control register fields and reset value
  localparam int CTRL_LINK_EN = 0;
  localparam logic CTRL_LINK_EN_RESET = 1'b1;

  // status register field positions
  localparam int STAT_SERIAL = 0;
  localparam int STAT_BYTE = 1;
  localparam int STAT_SEL = 2;
  localparam int STAT_CHAIN = 5;
  localparam int STAT_HBE = 6;
  localparam int STAT_BUF_FREE = 7;
  localparam int STAT_BUF_AVAIL = 8;
  localparam int STAT_FRAME = 9;

  // positions of the pin levels inside the synchroniser vector
  localparam int SY_CS = 16;
  localparam int SY_RD = 17;
  localparam int SY_SPS = 18;
  localparam int SY_WB = 19;

  // data pin roles
  localparam int DB_SEL_A = 0;
  localparam int DB_CHAIN_C = 3;
  localparam int DB_CHAIN_A = 5;
  localparam int DB_SCLK = 6;
  localparam int DB_BIT7 = 7;
  localparam int DB_DOUT_A = 8;

  // synchroniser reset: select strobes idle high so nothing drives after reset
  localparam logic [SYNC_W-1:0] SYNC_RESET = 20'h3_0000;

  // drive value and enable of the sixteen data pins
  typedef struct packed {
    logic [WORD_W-1:0] out;
    logic [WORD_W-1:0] oe;
  } pad_drive_t;

  // one word with its valid flag
  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] data;
  } word_slot_t;

  // role of the pin group
  typedef enum logic [1:0] {
    LINK_PAR,
    LINK_SER_WAIT,
    LINK_SER_FRAME
  } link_state_t;

  // two-entry buffer state: head feeds the reader directly
  typedef struct packed {
    word_slot_t head;
    word_slot_t tail;
  } buf_state_t;

  localparam buf_state_t BUF_RESET = '0;

  // whole state of the pin mux
  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic sclk_prev;
    logic cs_prev;
    logic rd_prev;
    link_state_t link;
    logic byte_half;
    logic [LINES-1:0][WORD_W-1:0] shreg;
    logic [WORD_W-1:0] chain_word;
    logic link_en;
    logic data_phase;
    logic ph_write;
    logic [7:0] ph_addr;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    pad_drive_t pad;
  } mux_state_t;

  localparam mux_state_t MUX_RESET = '{
    sync1: SYNC_RESET, sync2: SYNC_RESET, cs_prev: 1'b1, rd_prev: 1'b1,
    link: LINK_PAR, link_en: CTRL_LINK_EN_RESET, hreadyout: 1'b1,
    shreg: '0, chain_word: '0, ph_addr: '0, hrdata: '0, pad: '0,
    sclk_prev: 1'b0, byte_half: 1'b0, data_phase: 1'b0, ph_write: 1'b0, hresp: 1'b0
  };

endpackage

// >>> design/word_buffer.sv
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module word_buffer (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // filling side
  input wire pin_mux_pkg::word_slot_t in_word,
  output logic in_ready,
  // draining side
  output pin_mux_pkg::word_slot_t out_word,
  input wire logic out_ready
);
  import pin_mux_pkg::*;

  buf_state_t st;
  buf_state_t st_next;

  // head is the output register, so the reader never sees a mux path
  always_comb begin
    st_next = st;
    if (out_ready && st.head.valid) begin
      st_next.head = st.tail;
      st_next.tail.valid = 1'b0;
    end
    // a push is refused only while the tail holds a word
    if (in_word.valid && !st.tail.valid) begin
      if (!st_next.head.valid) begin
        st_next.head = in_word;
      end else begin
        st_next.tail = in_word;
      end
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= BUF_RESET;
    end else begin
      st <= st_next;
    end
  end

  assign in_ready = !st.tail.valid;
  assign out_word = st.head;

endmodule // word_buffer
`default_nettype wire

// >>> design/adc_data_pin_function_mux.sv
// shared data pin function mux of the converter host interface, with an ahb-lite register slave
//
// Summary of operation
// - A low serial/parallel select picks the parallel interface and a high one the serial one.
// - In parallel word mode every shared data pin is a three-state output bit with no serial role.
// - Parallel outputs drive only while chip select and read are both low; serial hosts hold read low.
// - In serial mode the output-C select pin enables serial output C when 1 and keeps it off when 0.
// - In serial mode with select A at 1, data bit 8 becomes serial output A and shifts results out.
// - In serial mode with select B at 1, data bit 9 becomes serial output B.
// - In serial mode with select C at 1, data bit 10 becomes serial output C.
// - In serial mode with chain enable at 1, data bits 3, 4 and 5 are chain inputs C, B and A.
// - In serial mode data bit 6 is the serial clock input that clocks out the read transfer.
// - In parallel word mode data bit 7 stays an ordinary data bit.
// - In parallel byte mode bit 7 picks high byte first when high, low byte first when low.
// - In serial mode bit 7 is the chain enable, high selecting daisy-chain operation.
//
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module adc_data_pin_function_mux (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // interface pins from the host
  input wire logic serial_parallel_select,
  input wire logic word_byte_select,
  input wire logic cs_n,
  input wire logic rd_n,
  // shared data pins
  input wire logic [15:0] db_in,
  output logic [15:0] db_out,
  output logic [15:0] db_oe
);
  import pin_mux_pkg::*;

  mux_state_t st;
  mux_state_t n;

  // buffer between the bus and the pins
  word_slot_t bf_in;
  word_slot_t bf_out;
  logic bf_in_ready;
  logic pop;
  logic push;

  // synchronised pin levels, always read from the second flip-flop
  logic [WORD_W-1:0] db_s;
  logic cs_s;
  logic rd_s;
  logic ser_s;
  logic wb_s;
  logic sclk_s;
  logic cs_fall;
  logic rd_rise;
  logic sclk_fall;
  logic chain_en;
  logic [LINES-1:0] sel;
  logic drive_par;
  logic [WORD_W-1:0] head_word;
  logic [31:0] status_word;
  logic [31:0] read_value;

  assign db_s = st.sync2[WORD_W-1:0];
  assign cs_s = st.sync2[SY_CS];
  assign rd_s = st.sync2[SY_RD];
  assign ser_s = st.sync2[SY_SPS];
  assign wb_s = st.sync2[SY_WB];
  assign sclk_s = db_s[DB_SCLK];
  assign chain_en = ser_s && db_s[DB_BIT7];
  assign sel = db_s[DB_SEL_A +: LINES];

  // edges found by the system clock; the 400 ns link clock gives eight samples a period
  assign cs_fall = st.cs_prev && !cs_s;
  assign rd_rise = !st.rd_prev && rd_s;
  assign sclk_fall = st.sclk_prev && !sclk_s;

  // an empty buffer reads as zero rather than stale data
  assign head_word = bf_out.valid ? bf_out.data : '0;

  // status register contents
  always_comb begin
    status_word = '0;
    status_word[STAT_SERIAL] = ser_s;
    status_word[STAT_BYTE] = !ser_s && wb_s;
    status_word[STAT_SEL +: LINES] = ser_s ? sel : '0;
    status_word[STAT_CHAIN] = chain_en;
    status_word[STAT_HBE] = !ser_s && wb_s && db_s[DB_BIT7];
    status_word[STAT_BUF_FREE] = bf_in_ready;
    status_word[STAT_BUF_AVAIL] = bf_out.valid;
    status_word[STAT_FRAME] = (st.link == LINK_SER_FRAME);
  end

  // register read mux; unmapped offsets read as zero
  always_comb begin
    case (st.ph_addr)
      OFS_CTRL: read_value = {31'h0000_0000, st.link_en};
      OFS_STATUS: read_value = status_word;
      OFS_CHAIN: read_value = {16'h0000, st.chain_word};
      default: read_value = 32'h0000_0000;
    endcase
  end

  // next state: pins, link roles, bus slave and pad drive
  always_comb begin
    n = st;
    pop = 1'b0;
    push = 1'b0;
    drive_par = 1'b0;
    // two-flop synchroniser for every pin input
    n.sync1 = {word_byte_select, serial_parallel_select, rd_n, cs_n, db_in};
    n.sync2 = st.sync1;
    n.sclk_prev = sclk_s;
    n.cs_prev = cs_s;
    n.rd_prev = rd_s;

    // role of the pin group
    case (st.link)
      LINK_PAR: begin
        if (ser_s) begin
          n.link = LINK_SER_WAIT;
          n.byte_half = 1'b0;
        end else if (rd_rise && !cs_s) begin
          // a word leaves after one word read or after its second byte
          if (!wb_s || st.byte_half) begin
            pop = bf_out.valid;
            n.byte_half = 1'b0;
          end else begin
            n.byte_half = 1'b1;
          end
        end
      end
      LINK_SER_WAIT: begin
        if (!ser_s) begin
          n.link = LINK_PAR;
        end else if (cs_fall) begin
          // each enabled line starts its frame with the head word, msb first
          n.link = LINK_SER_FRAME;
          pop = bf_out.valid;
          for (int i = 0; i < LINES; i++) begin
            n.shreg[i] = head_word;
          end
        end
      end
      LINK_SER_FRAME: begin
        if (!ser_s) begin
          n.link = LINK_PAR;
        end else if (cs_s) begin
          // line a ends the frame holding what the chain shifted in
          n.link = LINK_SER_WAIT;
          n.chain_word = st.shreg[0];
        end else if (sclk_fall) begin
          // line i takes chain input a, b, c from pins 5, 4, 3
          for (int i = 0; i < LINES; i++) begin
            n.shreg[i] = {st.shreg[i][WORD_W-2:0], chain_en && db_s[DB_CHAIN_A - i]};
          end
        end
      end
      default: begin
        n.link = LINK_PAR;
      end
    endcase

    // bus data phase; the slave always inserts at least one wait state
    if (st.data_phase) begin
      if (st.ph_write) begin
        if (st.ph_addr == OFS_DATA) begin
          // a full buffer holds the bus until a word drains
          if (bf_in_ready) begin
            push = 1'b1;
            n.data_phase = 1'b0;
            n.hreadyout = 1'b1;
          end
        end else begin
          if (st.ph_addr == OFS_CTRL) begin
            n.link_en = hwdata[CTRL_LINK_EN];
          end
          n.data_phase = 1'b0;
          n.hreadyout = 1'b1;
        end
      end else begin
        n.hrdata = read_value;
        n.data_phase = 1'b0;
        n.hreadyout = 1'b1;
      end
    end else if (hsel && htrans[1] && hready) begin
      n.data_phase = 1'b1;
      n.ph_write = hwrite;
      n.ph_addr = haddr[7:0];
      n.hreadyout = 1'b0;
    end

    // pad drive, registered so the pins never see a combinational glitch
    n.pad = '0;
    if (st.link_en && n.link == LINK_PAR && !cs_s && !rd_s) begin
      drive_par = 1'b1;
    end
    if (drive_par) begin
      if (!wb_s) begin
        n.pad.oe = '1;
        n.pad.out = head_word;
      end else begin
        // byte mode uses the upper eight lines; bit 7 is an input here
        n.pad.oe[15:8] = 8'hFF;
        if (db_s[DB_BIT7] ^ st.byte_half) begin
          n.pad.out[15:8] = head_word[15:8];
        end else begin
          n.pad.out[15:8] = head_word[7:0];
        end
      end
    end else if (st.link_en && n.link == LINK_SER_FRAME) begin
      // serial outputs only on selected lines; the rest stay released
      for (int i = 0; i < LINES; i++) begin
        n.pad.oe[DB_DOUT_A + i] = sel[i];
        n.pad.out[DB_DOUT_A + i] = n.shreg[i][WORD_W-1];
      end
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= MUX_RESET;
    end else begin
      st <= n;
    end
  end

  // buffer feeding the pins; its ready stalls bus writes to the data register
  assign bf_in = '{valid: push, data: hwdata[WORD_W-1:0]};

  word_buffer u_buffer (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_word(bf_in),
    .in_ready(bf_in_ready),
    .out_word(bf_out),
    .out_ready(pop)
  );

  // outputs straight from the state register
  assign hreadyout = st.hreadyout;
  assign hresp = st.hresp;
  assign hrdata = st.hrdata;
  assign db_out = st.pad.out;
  assign db_oe = st.pad.oe;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // no pin that serial mode leaves to ground is ever driven in serial mode
  chk_serial_top_quiet: assert property (
    $past(ser_s) |-> db_oe[15:11] == 5'h00
  ) else $error("top data pins driven in serial mode");

  // parallel pads only when both strobes were low in parallel mode
  chk_par_strobes: assert property (
    db_oe[15] |-> $past(!ser_s && !cs_s && !rd_s && st.link_en)
  ) else $error("parallel bus driven without both strobes low");

  // word mode drives all sixteen lines with the head word
  chk_word_mode_bits: assert property (
    $past(drive_par && !wb_s) |-> db_oe == 16'hFFFF && db_out == $past(head_word)
  ) else $error("word mode did not drive the full word");

  // bit 7 stays a data bit in word mode
  chk_word_bit7: assert property (
    $past(drive_par && !wb_s) |-> db_oe[DB_BIT7] && db_out[DB_BIT7] == $past(head_word[7])
  ) else $error("bit 7 not driven as data in word mode");

  // first byte follows the high byte first level
  chk_byte_order: assert property (
    $past(drive_par && wb_s && !st.byte_half) |->
      db_out[15:8] == ($past(db_s[DB_BIT7]) ? $past(head_word[15:8]) : $past(head_word[7:0]))
      && db_oe[7:0] == 8'h00
  ) else $error("byte order wrong in byte mode");

  // line a carries the msb of its shift register during a frame
  chk_dout_a_data: assert property (
    st.link == LINK_SER_FRAME && db_oe[DB_DOUT_A] |-> db_out[DB_DOUT_A] == st.shreg[0][WORD_W-1]
  ) else $error("serial output a does not follow its shift register");

  // output b enable follows select b within a frame
  chk_dout_b_gate: assert property (
    $past(st.link_en && ser_s && n.link == LINK_SER_FRAME) |-> db_oe[9] == $past(sel[1])
  ) else $error("serial output b enable does not follow select b");

  // output c is driven only with select c high
  chk_dout_c_gate: assert property (
    $past(st.link_en && ser_s && n.link == LINK_SER_FRAME) |-> db_oe[10] == $past(sel[2])
  ) else $error("serial output c enable does not follow select c");

  // a falling serial clock shifts line a by one place
  chk_sclk_shift: assert property (
    st.link == LINK_SER_FRAME && ser_s && !cs_s && sclk_fall |=>
      st.shreg[0][WORD_W-1:1] == $past(st.shreg[0][WORD_W-2:0])
  ) else $error("serial clock edge did not shift line a");

  // chain input a enters line a only with chain enable high
  chk_chain_input: assert property (
    st.link == LINK_SER_FRAME && ser_s && !cs_s && sclk_fall |=>
      st.shreg[0][0] == $past(db_s[DB_CHAIN_A] && db_s[DB_BIT7])
  ) else $error("chain input a not shifted in as enabled");

  // chain input b enters line b only with chain enable high
  chk_chain_input_b: assert property (
    st.link == LINK_SER_FRAME && ser_s && !cs_s && sclk_fall |=>
      st.shreg[1][0] == $past(db_s[DB_CHAIN_A - 1] && db_s[DB_BIT7])
  ) else $error("chain input b not shifted in as enabled");

  // chain input c enters line c only with chain enable high
  chk_chain_input_c: assert property (
    st.link == LINK_SER_FRAME && ser_s && !cs_s && sclk_fall |=>
      st.shreg[2][0] == $past(db_s[DB_CHAIN_C] && db_s[DB_BIT7])
  ) else $error("chain input c not shifted in as enabled");

  // without a falling serial clock edge the lines keep their bits
  chk_sclk_hold: assert property (
    st.link == LINK_SER_FRAME && ser_s && !cs_s && !sclk_fall |=>
      st.shreg == $past(st.shreg)
  ) else $error("lines shifted without a serial clock edge");

  // a raised strobe in parallel mode releases every pad
  chk_par_release: assert property (
    $past(!ser_s && (cs_s || rd_s)) |-> db_oe == 16'h0000
  ) else $error("parallel pads driven with a strobe high");

  // a low select keeps the pin group in its parallel role
  chk_par_role: assert property (
    $past(!ser_s) |-> st.link == LINK_PAR
  ) else $error("serial role taken in parallel mode");

  // the second byte is the one the first read left out
  chk_byte_second: assert property (
    $past(drive_par && wb_s && st.byte_half) |->
      db_out[15:8] == ($past(db_s[DB_BIT7]) ? $past(head_word[7:0]) : $past(head_word[15:8]))
  ) else $error("second byte wrong in byte mode");

endmodule // adc_data_pin_function_mux
`default_nettype wire

// >>> test/conv_host_model.sv
// host model: drives the mode and strobe pins and the data pins it owns, reads the pads
`timescale 1ns/10ps
`default_nettype none
module conv_host_model (
  // clock
  input wire logic hclk,
  // pads of the block
  input wire logic [15:0] db_out,
  input wire logic [15:0] db_oe,
  // host pins
  output logic serial_parallel_select,
  output logic word_byte_select,
  output logic cs_n,
  output logic rd_n,
  output logic [15:0] db_in
);
  logic [15:0] drv;
  logic [15:0] den;
  logic [15:0] pat;

  // idle levels at time zero: strobes high, nothing owned by the host
  initial begin
    serial_parallel_select = 1'b0;
    word_byte_select = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    drv = 16'h0000;
    den = 16'h0000;
    pat = 16'h5555;
  end

  // a bit nobody drives toggles every cycle, so a stale value is never mistaken for data
  always @(posedge hclk) begin
    pat <= ~pat;
  end

  // pin level from the block's enables, the host's enables, else the pattern
  always_comb begin
    db_in = (db_oe & db_out) | (~db_oe & den & drv) | (~db_oe & ~den & pat);
  end

  task automatic wait_n(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // mode pins; a serial host holds read low
  task automatic set_mode(input logic ser, input logic wb, input logic [15:0] d,
                          input logic [15:0] e);
    serial_parallel_select <= ser;
    word_byte_select <= wb;
    rd_n <= ~ser;
    drv <= d;
    den <= e;
    wait_n(8);
  endtask

  // one parallel read strobe; read rises while chip select is still low
  task automatic par_read(output logic [15:0] val, output logic [15:0] oe);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    wait_n(5);
    val = db_out;
    oe = db_oe;
    rd_n <= 1'b1;
    wait_n(5);
    cs_n <= 1'b1;
    wait_n(5);
  endtask

  // one serial frame of 16 clocks at 400 ns; the clock stands high outside frames
  task automatic frame(output logic [2:0][15:0] got, output logic [15:0] oe);
    cs_n <= 1'b0;
    wait_n(8);
    oe = db_oe;
    for (int i = 15; i >= 0; i--) begin
      got[0][i] = db_out[8]; // disabled lines are captured but never judged
      got[1][i] = db_out[9];
      got[2][i] = db_out[10];
      drv[6] <= 1'b0;
      wait_n(4);
      drv[6] <= 1'b1;
      wait_n(4);
    end
    cs_n <= 1'b1;
    wait_n(8);
  endtask
endmodule // conv_host_model
`default_nettype wire

// >>> test/adc_data_pin_function_mux_tb.sv
// testbench of the data pin function mux: bus tasks, host model and scenarios
`timescale 1ns/10ps
`default_nettype none
module adc_data_pin_function_mux_tb;
  import pin_mux_pkg::*;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic sps;
  logic wbs;
  logic cs_n;
  logic rd_n;
  logic [15:0] db_in;
  logic [15:0] db_out;
  logic [15:0] db_oe;
  int err_total;
  int samples_checked;

  assign hready = hreadyout;

  adc_data_pin_function_mux i_adc_data_pin_function_mux (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .serial_parallel_select(sps), .word_byte_select(wbs), .cs_n(cs_n), .rd_n(rd_n),
    .db_in(db_in), .db_out(db_out), .db_oe(db_oe));

  conv_host_model i_conv_host_model (
    .hclk(hclk), .db_out(db_out), .db_oe(db_oe), .serial_parallel_select(sps),
    .word_byte_select(wbs), .cs_n(cs_n), .rd_n(rd_n), .db_in(db_in));

  // 20 MHz clock
  initial hclk = 1'b0;
  always #25 hclk = ~hclk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one single ahb-lite transfer; waits on hready in both phases
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    ahb(1'b1, a, d, v);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    chk(nm, exp, v & m);
  endtask

  // reset values, unmapped place
  task automatic test_reset();
    logic [15:0] v;
    logic [15:0] oe;
    chk("db_oe reset", 32'h0, {16'h0, db_oe});
    rd_chk("ctrl reset", OFS_CTRL, 32'hFFFFFFFF, 32'h1);
    wr(8'h40, 32'hFFFFFFFF);
    rd_chk("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
    rd_chk("ctrl kept", OFS_CTRL, 32'hFFFFFFFF, 32'h1);
    // link enable off: a full strobe must leave the pads released
    wr(OFS_CTRL, 32'h0);
    rd_chk("ctrl off", OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    i_conv_host_model.par_read(v, oe);
    chk("link off oe", 32'h0, {16'h0, oe});
    wr(OFS_CTRL, 32'h1);
  endtask

  // word mode: fill until full, third write stalls while the pins drain one word
  task automatic test_word();
    logic [15:0] v;
    logic [15:0] oe;
    i_conv_host_model.set_mode(1'b0, 1'b0, 16'h0000, 16'h0000);
    wr(OFS_DATA, 32'h0000A5C3);
    wr(OFS_DATA, 32'h00005A3C);
    rd_chk("status full", OFS_STATUS, 32'h180, 32'h100);
    fork
      wr(OFS_DATA, 32'h00000F81);
      i_conv_host_model.par_read(v, oe);
    join
    chk("word 1", 32'hA5C3, v);
    chk("word oe", 32'hFFFF, oe);
    chk("oe released", 32'h0, db_oe);
    i_conv_host_model.par_read(v, oe);
    chk("word 2", 32'h5A3C, v);
    i_conv_host_model.par_read(v, oe);
    chk("word 3", 32'h0F81, v);
    i_conv_host_model.par_read(v, oe);
    chk("empty", 32'h0, v);
  endtask

  // byte mode with both byte orders
  task automatic test_byte();
    logic [15:0] v;
    logic [15:0] oe;
    logic [15:0] w;
    for (int h = 0; h < 2; h++) begin
      w = h ? 16'h12B4 : 16'hCD3A;
      i_conv_host_model.set_mode(1'b0, 1'b1, {8'h00, h[0], 7'h00}, 16'h0080);
      rd_chk("status byte", OFS_STATUS, 32'h43, h ? 32'h42 : 32'h02);
      wr(OFS_DATA, {16'h0, w});
      i_conv_host_model.par_read(v, oe);
      chk("byte oe", 32'hFF00, oe);
      chk("first byte", h ? w[15:8] : w[7:0], v[15:8]);
      i_conv_host_model.par_read(v, oe);
      chk("second byte", h ? w[7:0] : w[15:8], v[15:8]);
    end
  endtask

  // serial frames: lines A and B with chaining, then all three lines without it
  task automatic test_serial();
    logic [2:0][15:0] got;
    logic [15:0] oe;
    logic [15:0] w;
    logic [2:0] sel;
    logic ch;
    for (int k = 0; k < 2; k++) begin
      sel = k ? 3'b111 : 3'b011;
      ch = (k == 0);
      w = k ? 16'hC3A5 : 16'h9E01;
      i_conv_host_model.set_mode(1'b1, 1'b0, {8'h00, ch, 1'b1, ch, 1'b0, ch, sel},
                                 16'h00FF);
      wr(OFS_DATA, {16'h0, w});
      rd_chk("status serial", OFS_STATUS, 32'h3D, {26'h0, ch, sel, 2'b01});
      i_conv_host_model.frame(got, oe);
      chk("serial oe", {13'h0, sel}, {16'h0, oe} >> 8);
      chk("other oe", 32'h0, {16'h0, oe & 16'hF8FF});
      for (int j = 0; j < 3; j++) begin
        if (sel[j]) begin
          chk("serial word", w, got[j]);
        end
      end
      chk("frame end oe", 32'h0, db_oe);
      rd_chk("chain", OFS_CHAIN, 32'hFFFF, ch ? 32'hFFFF : 32'h0);
    end
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    finish_test();
  end

  // main sequence
  initial begin
    err_total = 0;
    samples_checked = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    test_reset();
    test_word();
    test_byte();
    test_serial();
    finish_test();
  end
endmodule // adc_data_pin_function_mux_tb
`default_nettype wire
